/* File: verilog/lswd_pkg.sv */
/*
 * Shared constants of the low speed watchdog timer: register offsets,
 * field positions, reset values, unlock keys and timing counts.
 * Assumes an 8-bit special-function-register bus with 8-bit offsets.
 */
package lswd_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] LSWD_RESET_CONTROL_OFS = 8'hab;
    localparam logic [7:0] LSWD_MAIN_CONTROL_OFS  = 8'hd8;
    localparam logic [7:0] LSWD_EXT_IRQ_EN_OFS    = 8'he8;
    localparam logic [7:0] LSWD_TIMED_KEY_OFS     = 8'hc7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LSWD_RUN_ENABLE_BIT    = 7;
    localparam int LSWD_COUNTER_CLEAR_BIT = 6;
    localparam int LSWD_TIMEOUT_FLAG_BIT  = 5;
    localparam int LSWD_RUN_IN_SLEEP_BIT  = 4;
    localparam int LSWD_RESET_FLAG_BIT    = 3;
    localparam int LSWD_INTERVAL_MSB      = 2;
    localparam int LSWD_RESET_FUNC_BIT    = 0;
    localparam int LSWD_IRQ_ENABLE_BIT    = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] LSWD_RESET_CONTROL_RST = 8'h00;
    localparam logic [7:0] LSWD_EXT_IRQ_EN_RST    = 8'h00;

    // ------------------------------------------------------------------
    // Timed access keys and window
    // ------------------------------------------------------------------
    localparam logic [7:0] LSWD_KEY_FIRST  = 8'haa;
    localparam logic [7:0] LSWD_KEY_SECOND = 8'h55;
    localparam int         LSWD_KEY_WINDOW = 4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int LSWD_CLK_PERIOD_NS  = 10;
    localparam int LSWD_SLOW_FREQ_HZ   = 10000;
    localparam int LSWD_SLOW_PERIOD_NS = 1000000000 / LSWD_SLOW_FREQ_HZ;
    localparam int LSWD_SLOW_DIV       = LSWD_SLOW_PERIOD_NS / LSWD_CLK_PERIOD_NS;
    localparam int LSWD_BASE_COUNT     = 64;
    localparam int LSWD_GRACE_COUNT    = 512;
    localparam int LSWD_CNT_W          = 15;
    localparam int LSWD_GRACE_W        = 10;

    // Interval code to prescale shift: divisors 1,2,8,16,32,64,128,256
    function automatic logic [3:0] lswd_shift(input logic [2:0] code);
        logic [3:0] s;
        s = 4'h0;
        case (code)
            3'h0: s = 4'h0;
            3'h1: s = 4'h1;
            3'h2: s = 4'h3;
            3'h3: s = 4'h4;
            3'h4: s = 4'h5;
            3'h5: s = 4'h6;
            3'h6: s = 4'h7;
            default: s = 4'h8;
        endcase
        return s;
    endfunction

endpackage

/* File: verilog/lswd_tick_div.sv */
/*
 * Divider that turns the system clock into a one-cycle enable pulse
 * at the slow watchdog rate.
 * Assumes one clock, asynchronous active-high reset.
 */
`timescale 1ns/10ps
module lswd_tick_div
    import lswd_pkg::*;
#(
    parameter int DIV = LSWD_SLOW_DIV
)(
    input  wire logic mclk_in,
    input  wire logic reset_in,
    output logic      tick_out
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } lswd_div_t;

    lswd_div_t st_q;
    lswd_div_t st_d;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == 16'(DIV - 1))
        begin
            st_d.cnt  = 16'h0000;
            st_d.tick = 1'b1;
        end
        else
        begin
            st_d.cnt = st_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign tick_out = st_q.tick;

endmodule

/* File: verilog/lswd_key_unlock.sv */
/*
 * Timed access unlock: two key writes in sequence open a short window
 * in which one protected register write is accepted.
 * Assumes single-cycle register write strobes on the system clock.
 */
`timescale 1ns/10ps
module lswd_key_unlock
    import lswd_pkg::*;
#(
    parameter int WINDOW = LSWD_KEY_WINDOW
)(
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       consume_in,
    output logic            open_out
);

    typedef struct packed {
        logic       first_seen;
        logic [3:0] left;
    } lswd_key_t;

    lswd_key_t st_q;
    lswd_key_t st_d;
    logic      key_wr;

    // ------------------------------------------------------------------
    // Key sequence
    // ------------------------------------------------------------------
    always_comb
    begin
        key_wr = wr_in && (addr_in == LSWD_TIMED_KEY_OFS);
        st_d   = st_q;
        if (st_q.left != 4'h0)
            st_d.left = st_q.left - 4'h1;
        if (consume_in)
            st_d.left = 4'h0;
        if (key_wr)
        begin
            if (st_q.first_seen && wdata_in == LSWD_KEY_SECOND)
            begin
                st_d.left       = 4'(WINDOW);
                st_d.first_seen = 1'b0;
            end
            else
            begin
                st_d.first_seen = (wdata_in == LSWD_KEY_FIRST);
            end
        end
        else if (wr_in)
        begin
            st_d.first_seen = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign open_out = (st_q.left != 4'h0);

endmodule

/* File: verilog/lswd_top.sv */
/*
 * Low speed watchdog timer: slow tick counter with selectable interval,
 * time-out flag and interrupt, delayed system reset, sleep handling and
 * timed-access protected control registers on the register bus.
 * Assumes a synchronous byte-wide register bus, a power-on indication
 * that stays high for at least one clock after reset is released, and a sleep level from
 * the core.
 */
`timescale 1ns/10ps
module lswd_top
    import lswd_pkg::*;
#(
    parameter int SLOW_DIV = LSWD_SLOW_DIV
)(
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       power_on_in,
    input  wire logic       config_watch_disable_in,
    input  wire logic       sleep_in,
    input  wire logic       sfr_wr_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic      [7:0] sfr_rdata_out,
    output logic            irq_out,
    output logic            wake_out,
    output logic            watch_reset_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                    watch_run_enable;
        logic                    load_config;
        logic                    counter_clear;
        logic                    timeout_irq_flag;
        logic                    run_in_sleep;
        logic                    watch_reset_flag;
        logic [2:0]              interval_select;
        logic                    watch_reset_function_enable;
        logic [7:0]              extended_interrupt_enable;
        logic [LSWD_CNT_W-1:0]   count;
        logic                    grace_armed;
        logic [LSWD_GRACE_W-1:0] grace;
        logic                    sleep_prev;
        logic [7:0]              rdata;
        logic                    irq;
        logic                    wake;
        logic                    wreset;
    } lswd_state_t;

    lswd_state_t st_q;
    lswd_state_t st_d;

    logic                  slow_tick;
    logic                  key_open;
    logic                  wr_main;
    logic                  wr_rctl;
    logic                  wr_eie;
    logic                  prot_wr;
    logic                  sleep_edge;
    logic                  counting;
    logic                  timeout;
    logic [LSWD_CNT_W-1:0] terminal;
    logic                  count_zero;
    logic                  grace_tick;
    logic                  grace_done;
    logic [7:0]            main_view;
    logic [7:0]            rctl_view;
    logic                  wd_run;
    logic                  wd_clear;
    logic                  wd_flag_keep;
    logic                  wd_sleep_run;
    logic                  wd_rflag_keep;
    logic [2:0]            wd_interval;
    logic                  wd_reset_func;

    // ------------------------------------------------------------------
    // Slow tick and unlock
    // ------------------------------------------------------------------
    lswd_tick_div #(
        .DIV        (SLOW_DIV)
    ) u_tick (
        .mclk_in    (mclk_in),
        .reset_in   (reset_in),
        .tick_out   (slow_tick)
    );

    lswd_key_unlock u_key (
        .mclk_in    (mclk_in),
        .reset_in   (reset_in),
        .wr_in      (sfr_wr_in),
        .addr_in    (sfr_addr_in),
        .wdata_in   (sfr_wdata_in),
        .consume_in (prot_wr),
        .open_out   (key_open)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    always_comb
    begin
        wr_main = 1'b0;
        wr_rctl = 1'b0;
        wr_eie  = 1'b0;
        if (sfr_wr_in && sfr_addr_in == LSWD_MAIN_CONTROL_OFS)
        begin
            wr_main = key_open;
        end
        else if (sfr_wr_in && sfr_addr_in == LSWD_RESET_CONTROL_OFS)
        begin
            wr_rctl = key_open;
        end
        else if (sfr_wr_in && sfr_addr_in == LSWD_EXT_IRQ_EN_OFS)
        begin
            wr_eie = 1'b1;
        end
        prot_wr = wr_main || wr_rctl;
    end

    // ------------------------------------------------------------------
    // Write data fields
    // ------------------------------------------------------------------
    always_comb
    begin
        wd_run        = sfr_wdata_in[LSWD_RUN_ENABLE_BIT];
        wd_clear      = sfr_wdata_in[LSWD_COUNTER_CLEAR_BIT];
        wd_flag_keep  = sfr_wdata_in[LSWD_TIMEOUT_FLAG_BIT];
        wd_sleep_run  = sfr_wdata_in[LSWD_RUN_IN_SLEEP_BIT];
        wd_rflag_keep = sfr_wdata_in[LSWD_RESET_FLAG_BIT];
        wd_interval   = sfr_wdata_in[LSWD_INTERVAL_MSB:0];
        wd_reset_func = sfr_wdata_in[LSWD_RESET_FUNC_BIT];
    end

    // ------------------------------------------------------------------
    // Counter control
    // ------------------------------------------------------------------
    always_comb
    begin
        terminal   = (LSWD_CNT_W'(LSWD_BASE_COUNT) << lswd_shift(st_q.interval_select))
                     - LSWD_CNT_W'(1);
        sleep_edge = (sleep_in != st_q.sleep_prev);
        counting   = st_q.watch_run_enable && (!sleep_in || st_q.run_in_sleep);
        timeout    = counting && slow_tick && (st_q.count == terminal);
        count_zero = !st_q.watch_run_enable || st_q.counter_clear || sleep_edge;
        grace_tick = st_q.grace_armed && slow_tick && !count_zero;
        grace_done = grace_tick && (st_q.grace == LSWD_GRACE_W'(LSWD_GRACE_COUNT - 1));
    end

    // ------------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------------
    always_comb
    begin
        main_view                         = 8'h00;
        main_view[LSWD_RUN_ENABLE_BIT]    = st_q.watch_run_enable;
        main_view[LSWD_COUNTER_CLEAR_BIT] = 1'b0;
        main_view[LSWD_TIMEOUT_FLAG_BIT]  = st_q.timeout_irq_flag;
        main_view[LSWD_RUN_IN_SLEEP_BIT]  = st_q.run_in_sleep;
        main_view[LSWD_RESET_FLAG_BIT]    = st_q.watch_reset_flag;
        main_view[LSWD_INTERVAL_MSB:0]    = st_q.interval_select;
        rctl_view                         = 8'h00;
        rctl_view[LSWD_RESET_FUNC_BIT]    = st_q.watch_reset_function_enable;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d               = st_q;
        st_d.counter_clear = 1'b0;
        st_d.sleep_prev    = sleep_in;
        st_d.wake          = 1'b0;
        st_d.wreset        = 1'b0;

        // --------------------------------------------------------------
        // Configuration load after reset
        // --------------------------------------------------------------
        if (st_q.load_config)
        begin
            st_d.watch_run_enable = !config_watch_disable_in;
            st_d.load_config      = 1'b0;
        end

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (wr_main)
        begin
            st_d.watch_run_enable = wd_run;
            st_d.counter_clear    = wd_clear;
            st_d.run_in_sleep     = wd_sleep_run;
            st_d.interval_select  = wd_interval;
            if (!wd_flag_keep)
            begin
                st_d.timeout_irq_flag = 1'b0;
            end
            if (!wd_rflag_keep)
            begin
                st_d.watch_reset_flag = 1'b0;
            end
        end
        if (wr_rctl)
        begin
            st_d.watch_reset_function_enable = wd_reset_func;
        end
        if (wr_eie)
        begin
            st_d.extended_interrupt_enable = sfr_wdata_in;
        end

        // --------------------------------------------------------------
        // Counter
        // --------------------------------------------------------------
        if (count_zero)
        begin
            st_d.count       = '0;
            st_d.grace_armed = 1'b0;
            st_d.grace       = '0;
        end
        else if (counting && slow_tick)
        begin
            if (timeout)
            begin
                st_d.count            = '0;
                st_d.timeout_irq_flag = 1'b1;
                st_d.wake             = sleep_in;
                if (st_q.watch_reset_function_enable && !st_q.grace_armed)
                begin
                    st_d.grace_armed = 1'b1;
                    st_d.grace       = '0;
                end
            end
            else
            begin
                st_d.count = st_q.count + LSWD_CNT_W'(1);
            end
        end

        // --------------------------------------------------------------
        // Reset grace period, cut by any counter clear
        // --------------------------------------------------------------
        if (grace_done)
        begin
            st_d.grace_armed      = 1'b0;
            st_d.wreset           = 1'b1;
            st_d.watch_reset_flag = 1'b1;
        end
        else if (grace_tick)
        begin
            st_d.grace = st_q.grace + LSWD_GRACE_W'(1);
        end

        // --------------------------------------------------------------
        // Power-on clears the retained fields
        // --------------------------------------------------------------
        if (power_on_in)
        begin
            st_d.watch_reset_flag            = 1'b0;
            st_d.run_in_sleep                = 1'b0;
            st_d.interval_select             = 3'h0;
            st_d.watch_reset_function_enable = 1'b0;
        end

        st_d.irq = st_d.timeout_irq_flag
                   && st_d.extended_interrupt_enable[LSWD_IRQ_ENABLE_BIT];

        // --------------------------------------------------------------
        // Read data
        // --------------------------------------------------------------
        if (sfr_addr_in == LSWD_MAIN_CONTROL_OFS)
        begin
            st_d.rdata = main_view;
        end
        else if (sfr_addr_in == LSWD_RESET_CONTROL_OFS)
        begin
            st_d.rdata = rctl_view;
        end
        else if (sfr_addr_in == LSWD_EXT_IRQ_EN_OFS)
        begin
            st_d.rdata = st_q.extended_interrupt_enable;
        end
        else
        begin
            st_d.rdata = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            // Retained fields keep their values through this reset
            st_q.watch_run_enable          <= 1'b0;
            st_q.load_config               <= 1'b1;
            st_q.counter_clear             <= 1'b0;
            st_q.timeout_irq_flag          <= 1'b0;
            st_q.extended_interrupt_enable <= LSWD_EXT_IRQ_EN_RST;
            st_q.count                     <= '0;
            st_q.grace_armed               <= 1'b0;
            st_q.grace                     <= '0;
            st_q.sleep_prev                <= 1'b0;
            st_q.rdata                     <= 8'h00;
            st_q.irq                       <= 1'b0;
            st_q.wake                      <= 1'b0;
            st_q.wreset                    <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sfr_rdata_out   = st_q.rdata;
    assign irq_out         = st_q.irq;
    assign wake_out        = st_q.wake;
    assign watch_reset_out = st_q.wreset;

endmodule

/* File: bench/lswd_sva.sv */
/*
 * Port checker of the low speed watchdog top.
 * Assumes it is bound to lswd_top and sees only its ports.
 */
`timescale 1ns/10ps
module lswd_sva
    import lswd_pkg::*;
#(
    parameter int SLOW_DIV = LSWD_SLOW_DIV
)(
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       sleep_in,
    input  wire logic       sfr_wr_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic [7:0] sfr_rdata_out,
    input  wire logic       irq_out,
    input  wire logic       wake_out,
    input  wire logic       watch_reset_out
);
    logic [19:0] cyc_q;
    logic [19:0] quiet_q;
    logic        sleep_q;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    // -----------------------------
    // Cycles since reset and since a sleep edge
    // -----------------------------
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cyc_q   <= 20'h0;
            quiet_q <= 20'h0;
            sleep_q <= 1'b0;
        end
        else
        begin
            sleep_q <= sleep_in;
            cyc_q   <= cyc_q + 20'h1;
            quiet_q <= (sleep_in != sleep_q) ? 20'h0 : quiet_q + 20'h1;
        end
    end

    sequence s_ie_write;
        sfr_wr_in && sfr_addr_in == LSWD_EXT_IRQ_EN_OFS ##1 sfr_addr_in == LSWD_EXT_IRQ_EN_OFS;
    endsequence
    sequence s_ie_off;
        sfr_wr_in && sfr_addr_in == LSWD_EXT_IRQ_EN_OFS && !sfr_wdata_in[LSWD_IRQ_ENABLE_BIT];
    endsequence

    chk_ie_readback: assert property (s_ie_write |=> sfr_rdata_out == $past(sfr_wdata_in, 2))
        else $error("irq enable readback wrong");
    chk_irq_masked: assert property (s_ie_off |=> ##1 !irq_out)
        else $error("irq still high after mask");
    chk_irq_not_early: assert property ($rose(irq_out) |-> cyc_q >= 63 * SLOW_DIV)
        else $error("irq before shortest interval");
    chk_wake_pulse: assert property (wake_out |=> !wake_out)
        else $error("wake longer than one cycle");
    chk_wake_in_sleep: assert property (wake_out |-> $past(sleep_in))
        else $error("wake outside sleep");
    chk_wake_after_clear: assert property (wake_out |-> quiet_q >= 63 * SLOW_DIV)
        else $error("count not cleared on sleep edge");
    chk_reset_pulse: assert property (watch_reset_out |=> !watch_reset_out)
        else $error("reset request longer than one cycle");
    chk_grace_min: assert property (watch_reset_out |-> quiet_q >= 575 * SLOW_DIV)
        else $error("reset request too early");
    chk_clear_reads_zero: assert property (sfr_addr_in == LSWD_MAIN_CONTROL_OFS |=> !sfr_rdata_out[6])
        else $error("counter clear reads one");
    chk_ctl_upper_zero: assert property (sfr_addr_in == LSWD_RESET_CONTROL_OFS |=> sfr_rdata_out[7:1] == 7'h0)
        else $error("reset control upper bits set");
endmodule

bind lswd_top lswd_sva #(.SLOW_DIV(SLOW_DIV)) lswd_sva_inst (.mclk_in(mclk_in), .reset_in(reset_in),
    .sleep_in(sleep_in), .sfr_wr_in(sfr_wr_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .irq_out(irq_out),
    .wake_out(wake_out), .watch_reset_out(watch_reset_out));

/* File: bench/test_low_speed_watchdog_timer.sv */
/*
 * Self-checking bench of the low speed watchdog: registers, intervals,
 * interrupt, delayed reset and sleep handling.
 * Assumes lswd_sva is bound to the top and a shortened slow divider.
 */
`timescale 1ns/10ps
module test_low_speed_watchdog_timer
    import lswd_pkg::*;
;
    localparam int SD = 2;
    localparam logic [7:0] MC_A = LSWD_MAIN_CONTROL_OFS;
    localparam logic [7:0] RC_A = LSWD_RESET_CONTROL_OFS;
    localparam logic [7:0] IE_A = LSWD_EXT_IRQ_EN_OFS;

    logic       mclk_in = 1'b0;
    logic       reset_in = 1'b1;
    logic       power_on_in = 1'b1;
    logic       cfg_dis = 1'b0;
    logic       sleep_in = 1'b0;
    logic       wr = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [7:0] wdata = 8'h0;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    logic       wrst;
    logic [7:0] v;
    int         errors = 0;
    int         n_compared = 0;
    int         n;

`define CHK(got, exp, msg) \
    begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp); end end

    always #5 mclk_in = ~mclk_in;

    lswd_top #(.SLOW_DIV(SD)) lswd_top_inst (
        .mclk_in(mclk_in), .reset_in(reset_in), .power_on_in(power_on_in),
        .config_watch_disable_in(cfg_dis), .sleep_in(sleep_in), .sfr_wr_in(wr),
        .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
        .irq_out(irq), .wake_out(wake), .watch_reset_out(wrst));

    // -----------------------------
    // Expectations and bus tasks
    // -----------------------------
    function automatic int exp_to(input int k);
        int dv[8] = '{1, 2, 8, 16, 32, 64, 128, 256};
        return 64 * dv[k] * SD;
    endfunction

    function automatic logic near(input int c, input int e);
        return (c >= e - SD - 4) && (c <= e + SD + 4);
    endfunction

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask

    task automatic wr_prot(input logic [7:0] a, input logic [7:0] d);
        wr_reg(LSWD_TIMED_KEY_OFS, LSWD_KEY_FIRST);
        wr_reg(LSWD_TIMED_KEY_OFS, LSWD_KEY_SECOND);
        wr_reg(a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string m);
        @(posedge mclk_in);
        addr <= a;
        repeat (2) @(posedge mclk_in);
        #1;
        `CHK(rdata, e, m)
    endtask

    // Counts cycles until the chosen output is high, up to the limit
    task automatic wait_sig(input int s, input int lim, input bit must, output int c);
        #1;
        c = 0;
        while ((s == 0 ? irq : (s == 1 ? wake : wrst)) !== 1'b1 && c < lim)
        begin
            @(posedge mclk_in);
            #1;
            c++;
        end
        if (must && c >= lim)
        begin
            errors++;
            $display("MISMATCH t=%0t wait limit used up", $time);
            end_of_test();
        end
    endtask

    // -----------------------------
    // Main sequence
    // -----------------------------
    initial
    begin
        void'($urandom(32'h7813));
        @(posedge mclk_in);
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        power_on_in <= 1'b0;
        rd_chk(MC_A, 8'h80, "main after power-on");
        rd_chk(RC_A, 8'h00, "reset control after power-on");
        rd_chk(IE_A, 8'h00, "irq enable after power-on");
        rd_chk(8'h10, 8'h00, "unmapped read");
        wr_reg(MC_A, 8'h07);
        rd_chk(MC_A, 8'h80, "locked write dropped");
        $display("test reset_values done");

        for (int k = 0; k < 8; k++)
        begin
            v = 8'($urandom) | 8'h10;
            wr_reg(IE_A, v);
            rd_chk(IE_A, v, "irq enable storage");
            wr_prot(MC_A, 8'h00);
            wr_prot(MC_A, 8'h80 | 8'(k));
            wait_sig(0, exp_to(k) + 64, 1'b1, n);
            `CHK(near(n, exp_to(k)), 1'b1, "interval length")
            rd_chk(MC_A, 8'ha0 | 8'(k), "flag after time-out");
            wr_reg(IE_A, v & 8'hef);
            repeat (2) @(posedge mclk_in);
            #1;
            `CHK(irq, 1'b0, "irq masked")
            wr_prot(MC_A, 8'h80 | 8'(k));
            rd_chk(MC_A, 8'h80 | 8'(k), "flag cleared by zero");
        end
        $display("test intervals done");

        wr_prot(RC_A, 8'h01);
        rd_chk(RC_A, 8'h01, "reset function on");
        wr_reg(IE_A, 8'h10);
        wr_prot(MC_A, 8'h00);
        wr_prot(MC_A, 8'h90);
        wait_sig(0, 64 * SD + 64, 1'b1, n);
        repeat (400 * SD) @(posedge mclk_in);
        wr_prot(MC_A, 8'hd0);
        rd_chk(MC_A, 8'h90, "counter clear self-clears");
        wait_sig(2, 512 * SD, 1'b0, n);
        `CHK(n, 512 * SD, "clear cancels reset")
        wr_prot(MC_A, 8'hd0);
        wait_sig(0, 64 * SD + 64, 1'b1, n);
        wait_sig(2, 512 * SD + 64, 1'b1, n);
        `CHK(near(n, 512 * SD), 1'b1, "reset delay")
        @(posedge mclk_in);
        reset_in <= 1'b1;
        cfg_dis  <= 1'b1;
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        rd_chk(MC_A, 8'h18, "main after watchdog reset");
        rd_chk(RC_A, 8'h01, "reset function kept");
        @(posedge mclk_in);
        reset_in    <= 1'b1;
        power_on_in <= 1'b1;
        cfg_dis     <= 1'b0;
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        power_on_in <= 1'b0;
        rd_chk(MC_A, 8'h80, "main after power-on again");
        rd_chk(RC_A, 8'h00, "reset function cleared");
        $display("test reset_delay done");

        wr_reg(IE_A, 8'h10);
        wr_prot(MC_A, 8'h80);
        repeat ($urandom_range(20, 50) * SD) @(posedge mclk_in);
        sleep_in <= 1'b1;
        wait_sig(0, 3 * 64 * SD, 1'b0, n);
        `CHK(n, 3 * 64 * SD, "halted in sleep")
        @(posedge mclk_in);
        sleep_in <= 1'b0;
        wait_sig(0, 64 * SD + 64, 1'b1, n);
        `CHK(near(n, 64 * SD), 1'b1, "count cleared on wake")
        wr_prot(MC_A, 8'h90);
        repeat ($urandom_range(20, 50) * SD) @(posedge mclk_in);
        sleep_in <= 1'b1;
        wait_sig(1, 64 * SD + 64, 1'b1, n);
        `CHK(near(n, 64 * SD), 1'b1, "wake from sleep")
        @(posedge mclk_in);
        sleep_in <= 1'b0;
        rd_chk(MC_A, 8'hb0, "flag after sleep time-out");
        $display("test sleep done");
        end_of_test();
    end
endmodule
